// file: src/optld_pkg.sv
/*
 * Package for the option and trim loader: register offsets, field layout,
 * reset values, flash addresses and shared types.
 * Assumes a byte-wide register port and a byte-wide flash read port.
 */
package optld_pkg;
   // register offsets (12-bit register space)
   localparam logic [11:0] TRIM_INDEX_OFF = 12'hFF6;
   localparam logic [11:0] TRIM_DATA_OFF = 12'hFF7;
   localparam logic [11:0] PAGE_PICK_OFF = 12'hFF9;
   localparam logic [7:0] TRIM_INDEX_RST = 8'h00;
   localparam logic [7:0] TRIM_DATA_RST = 8'h00;
   localparam logic [7:0] PAGE_PICK_RST = 8'h00;
   localparam int TRIM_IDX_MSB = 4;
   localparam int INFO_SEL_BIT = 7;
   localparam int TRIM_COUNT = 32;
   // flash addresses
   localparam logic [15:0] USER_OPT0_ADDR = 16'h0000;
   localparam logic [15:0] USER_OPT1_ADDR = 16'h0001;
   localparam logic [15:0] INFO_BASE = 16'hFC00;
   localparam logic [5:0] TRIM_INFO_BASE = 6'h20;
   localparam logic [5:0] FOPT_INFO_LAST = 6'h1F;
   localparam logic [15:0] FOPT_COUNT = 16'h0020;
   // erased-flash option defaults
   localparam logic [7:0] USER_OPT0_RST = 8'hFF;
   localparam logic [7:0] USER_OPT1_RST = 8'hFF;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] opt0;
      logic [7:0] opt1;
   } user_opt_t;
endpackage

// file: src/option_and_trim_loader.sv
/*
 * Option and trim loader: copies user option bits from flash at reset,
 * holds 32 trim working bytes behind an index/data portal, keeps factory
 * option working values for the debug unit, and maps the information area.
 * Assumes a flash read port answering each request with a valid strobe after any delay, and a
 * reset request input from the system reset controller.
 */
// The strobed register port is this design's own decision.
// Contract
// - new option bits act only after reset
// - load options on reset and stop recovery
// - loading finishes before system reset ends
// - option registers invisible to software bus
// - options from flash bytes zero and one
// - page zero erase wipes option bits
// - trim factory values kept, working copies volatile
// - thirty-two byte trim entries via portal
// - index write then data write updates entry
// - index write then data read returns entry
// - index n maps to info location n+20h
// - portal reaches only info 20h to 3Fh
// - index bits 4:0, bits 7:5 reserved
// - data register passes full byte both ways
// - factory options written only by unlocked debugger
// - debugger reads factory option working values
// - info select reads FC00h-FC1Fh factory options
// - info select reads FC40h-FC57h device data
// - select bit 7 maps info at FC00h-FFFFh
`timescale 1ns/1ps
`default_nettype none
module option_and_trim_loader
   import optld_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_reset_req,
   input wire logic i_stop_recover,
   input wire logic [11:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_flash_rd,
   output logic [15:0] o_flash_addr,
   output logic o_info_rd,
   output logic [5:0] o_info_addr,
   input wire logic [7:0] i_flash_rdata,
   input wire logic i_flash_valid,
   input wire logic [15:0] i_prog_addr,
   output logic o_info_mapped,
   input wire logic i_dbg_opt_wr,
   input wire logic i_dbg_opt_rd,
   input wire logic [4:0] i_dbg_opt_idx,
   input wire logic [7:0] i_dbg_opt_wdata,
   input wire logic i_info_locked,
   output logic [7:0] o_dbg_opt_rdata,
   output logic [7:0] o_user_opt0,
   output logic [7:0] o_user_opt1,
   output logic o_sys_hold,
   output logic [4:0] o_trim_sel,
   output logic [7:0] o_trim_val
);

   //------------------------------------------------------------
   // bus request and state
   //------------------------------------------------------------
   reg_req_t req;
   assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

   typedef enum logic [2:0] {
      LD_TRIM, LD_FOPT, LD_OPT0, LD_OPT1, LD_DONE
   } load_state_t;
   load_state_t state;
   logic req_out;
   logic [5:0] cnt;
   logic [4:0] trim_index;
   logic [7:0] page_pick;
   logic [7:0] trim_mem [TRIM_COUNT];
   logic [7:0] fopt_mem [TRIM_COUNT];
   user_opt_t opt_cfg;
   logic load_go;
   assign load_go = i_reset_req | i_stop_recover;

   //------------------------------------------------------------
   // loader sequencer
   //------------------------------------------------------------
   // trim and factory copies load at power-on only; a later reset or stop
   // recovery reloads just the user options so volatile working edits
   // survive until power is lost
   // req_out marks a fetch in flight: set with the strobe, cleared by the answer or by load_go,
   // so a slow array sees a second request stacked behind it only after load_go lands mid-fetch
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= LD_TRIM;
         cnt <= 6'h00;
         req_out <= 1'b0;
      end else if (load_go) begin
         state <= LD_OPT0;
         req_out <= 1'b0;
      end else begin
         unique case (state)
            LD_TRIM: begin
               req_out <= ~i_flash_valid;
               if (i_flash_valid) begin
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'(TRIM_COUNT - 1)) begin
                     state <= LD_FOPT;
                     cnt <= 6'h00;
                  end
               end
            end
            LD_FOPT: begin
               req_out <= ~i_flash_valid;
               if (i_flash_valid) begin
                  cnt <= cnt + 6'h01;
                  if (cnt == FOPT_INFO_LAST) begin
                     state <= LD_OPT0;
                  end
               end
            end
            LD_OPT0: begin
               req_out <= ~i_flash_valid;
               if (i_flash_valid) begin
                  state <= LD_OPT1;
               end
            end
            LD_OPT1: begin
               req_out <= ~i_flash_valid;
               if (i_flash_valid) begin
                  state <= LD_DONE;
               end
            end
            LD_DONE: req_out <= 1'b0;
         endcase
      end
   end

   // read request strobes toward flash: one cycle, then wait for valid
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flash_rd <= 1'b0;
         o_info_rd <= 1'b0;
         o_flash_addr <= 16'h0000;
         o_info_addr <= 6'h00;
      end else begin
         o_flash_rd <= 1'b0;
         o_info_rd <= 1'b0;
         if (!load_go && !req_out && !i_flash_valid) begin
            unique case (state)
               LD_TRIM: begin
                  o_info_rd <= 1'b1;
                  o_info_addr <= TRIM_INFO_BASE + cnt;
               end
               LD_FOPT: begin
                  o_info_rd <= 1'b1;
                  o_info_addr <= cnt;
               end
               LD_OPT0: begin
                  o_flash_rd <= 1'b1;
                  o_flash_addr <= USER_OPT0_ADDR;
               end
               LD_OPT1: begin
                  o_flash_rd <= 1'b1;
                  o_flash_addr <= USER_OPT1_ADDR;
               end
               LD_DONE: ;
            endcase
         end
      end
   end

   // processor stays in reset until every option byte is loaded
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sys_hold <= 1'b1;
      end else begin
         o_sys_hold <= load_go | (state != LD_DONE);
      end
   end

   //------------------------------------------------------------
   // hidden option configuration registers
   //------------------------------------------------------------
   // captured only during a load, so flash programming has no effect until
   // the next reset or stop recovery; an erased page 0 reads all ones and loads as such
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         opt_cfg <= '{opt0: USER_OPT0_RST, opt1: USER_OPT1_RST};
      end else if (i_flash_valid && !load_go) begin
         if (state == LD_OPT0) begin
            opt_cfg.opt0 <= i_flash_rdata;
         end
         if (state == LD_OPT1) begin
            opt_cfg.opt1 <= i_flash_rdata;
         end
      end
   end
   assign o_user_opt0 = opt_cfg.opt0;
   assign o_user_opt1 = opt_cfg.opt1;

   //------------------------------------------------------------
   // trim working copies and portal
   //------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (state == LD_TRIM && i_flash_valid && !load_go) begin
         trim_mem[cnt[4:0]] <= i_flash_rdata;
      end else if (req.wr && req.addr == TRIM_DATA_OFF) begin
         trim_mem[trim_index] <= req.wdata;
      end
   end

   // index holds until rewritten; data accesses never move it
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         trim_index <= TRIM_INDEX_RST[TRIM_IDX_MSB:0];
      end else if (req.wr && req.addr == TRIM_INDEX_OFF) begin
         trim_index <= req.wdata[TRIM_IDX_MSB:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_trim_sel <= 5'h00;
         o_trim_val <= 8'h00;
      end else begin
         o_trim_sel <= trim_index;
         o_trim_val <= trim_mem[trim_index];
      end
   end

   //------------------------------------------------------------
   // page pick register and information area mapping
   //------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         page_pick <= PAGE_PICK_RST;
      end else if (req.wr && req.addr == PAGE_PICK_OFF) begin
         page_pick <= req.wdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_info_mapped <= 1'b0;
      end else begin
         o_info_mapped <= page_pick[INFO_SEL_BIT] && (i_prog_addr >= INFO_BASE);
      end
   end

   //------------------------------------------------------------
   // factory option working values for the debug unit
   //------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (state == LD_FOPT && i_flash_valid && !load_go) begin
         fopt_mem[cnt[4:0]] <= i_flash_rdata;
      end else if (i_dbg_opt_wr && !i_info_locked) begin
         fopt_mem[i_dbg_opt_idx] <= i_dbg_opt_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dbg_opt_rdata <= 8'h00;
      end else if (i_dbg_opt_rd) begin
         o_dbg_opt_rdata <= fopt_mem[i_dbg_opt_idx];
      end
   end

   //------------------------------------------------------------
   // register read port, data one cycle after the strobe
   //------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            TRIM_INDEX_OFF: o_reg_rdata <= {3'h0, trim_index};
            TRIM_DATA_OFF: o_reg_rdata <= trim_mem[trim_index];
            PAGE_PICK_OFF: o_reg_rdata <= page_pick;
            default: o_reg_rdata <= 8'h00;
         endcase
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   // loader sequencing and the processor hold
   hold_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state != LD_DONE) |=> o_sys_hold)
      else $error("released before load done");
   hold_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == LD_DONE && !load_go) |=> !o_sys_hold)
      else $error("hold kept after load done");
   reload_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      load_go |=> (state == LD_OPT0))
      else $error("reset did not reload options");
   // a stacked second fetch would shift every later byte into the wrong slot
   fetch_single_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (o_flash_rd || o_info_rd) |-> req_out)
      else $error("fetch strobe not tracked");
   fetch_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (o_flash_rd || o_info_rd) |=> !(o_flash_rd || o_info_rd))
      else $error("fetch strobe longer than one cycle");

   // hidden option bytes
   opt_stable_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == LD_DONE && !load_go) |=> $stable(opt_cfg))
      else $error("options changed outside a load");
   opt0_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == LD_OPT0 && i_flash_valid && !load_go)
      |=> (o_user_opt0 == $past(i_flash_rdata)))
      else $error("option byte zero not captured");
   opt1_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == LD_OPT1 && i_flash_valid && !load_go)
      |=> (o_user_opt1 == $past(i_flash_rdata)))
      else $error("option byte one not captured");
   opt_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_flash_rd |-> (o_flash_addr == USER_OPT0_ADDR || o_flash_addr == USER_OPT1_ADDR))
      else $error("option fetch address wrong");

   // trim portal and its index
   trim_rng_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (o_info_rd && state == LD_TRIM) |-> (o_info_addr >= TRIM_INFO_BASE))
      else $error("trim fetch outside 20h-3Fh");
   idx_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !(req.wr && req.addr == TRIM_INDEX_OFF) |=> $stable(trim_index))
      else $error("trim index moved");
   idx_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (req.wr && req.addr == TRIM_INDEX_OFF)
      |=> (trim_index == $past(req.wdata[TRIM_IDX_MSB:0])))
      else $error("trim index write lost");
   idx_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (req.rd && req.addr == TRIM_INDEX_OFF) |=> (o_reg_rdata[7:5] == 3'h0))
      else $error("reserved index bits nonzero");
   portal_rd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (req.rd && req.addr == TRIM_DATA_OFF) |=> (o_reg_rdata == trim_mem[$past(trim_index)]))
      else $error("portal read mismatch");
   portal_wr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (req.wr && req.addr == TRIM_DATA_OFF && state != LD_TRIM)
      |=> (trim_mem[$past(trim_index)] == $past(req.wdata)))
      else $error("portal write lost");
   trim_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      1'b1 |=> (o_trim_sel == $past(trim_index)))
      else $error("trim select lags index");
   trim_val_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == LD_DONE) |=> (o_trim_val == $past(trim_mem[trim_index])))
      else $error("trim value not selected entry");

   // register read port
   rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !req.rd |=> (o_reg_rdata == 8'h00))
      else $error("read data outside its slot");
   unmapped_rd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (req.rd && req.addr != TRIM_INDEX_OFF && req.addr != TRIM_DATA_OFF
         && req.addr != PAGE_PICK_OFF) |=> (o_reg_rdata == 8'h00))
      else $error("unmapped read not zero");

   // information area window
   map_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (page_pick[INFO_SEL_BIT] && i_prog_addr >= INFO_BASE) |=> o_info_mapped)
      else $error("info area not mapped");
   unmap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!page_pick[INFO_SEL_BIT] || i_prog_addr < INFO_BASE) |=> !o_info_mapped)
      else $error("info area mapped while off");

   // factory option working values
   lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_dbg_opt_wr && i_info_locked && state == LD_DONE)
      |=> (fopt_mem[$past(i_dbg_opt_idx)] == $past(fopt_mem[i_dbg_opt_idx])))
      else $error("locked factory option written");
   dbg_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_dbg_opt_wr && !i_info_locked && state == LD_DONE)
      |=> (fopt_mem[$past(i_dbg_opt_idx)] == $past(i_dbg_opt_wdata)))
      else $error("factory option write lost");
   dbg_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_dbg_opt_rd && state == LD_DONE)
      |=> (o_dbg_opt_rdata == $past(fopt_mem[i_dbg_opt_idx])))
      else $error("factory option read mismatch");

endmodule
`default_nettype wire

// file: verif/flash_partner_model.sv
/*
 * Behavioural flash array seen by the loader: program bytes 0000h/0001h
 * and a fixed information area pattern, answering promptly or slowly.
 * Assumes one outstanding request, as the loader keeps except when a reset request or stop recovery lands mid-fetch.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_partner_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_flash_rd,
   input wire logic [15:0] i_flash_addr,
   input wire logic i_info_rd,
   input wire logic [5:0] i_info_addr,
   input wire logic i_slow,
   input wire logic [7:0] i_opt0,
   input wire logic [7:0] i_opt1,
   output logic [7:0] o_flash_rdata,
   output logic o_flash_valid
);
   // ----------------------------------------
   // request capture and answer
   // ----------------------------------------
   logic [7:0] data;
   logic [7:0] last;
   logic busy;
   int wait_n;
   // slow mode adds three idle cycles so the loader cannot assume latency
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         busy <= 1'b0;
         wait_n <= 0;
         o_flash_valid <= 1'b0;
         last <= 8'h00;
         data <= 8'h00;
      end else begin
         o_flash_valid <= 1'b0;
         if (i_flash_rd || i_info_rd) begin
            busy <= 1'b1;
            wait_n <= i_slow ? 3 : 0;
            // factory pattern is fixed, user bytes sit at 0000h and 0001h
            data <= i_info_rd ? (({2'b00, i_info_addr} * 8'h1D) ^ 8'hA5)
                  : (i_flash_addr[0] ? i_opt1 : i_opt0);
         end else if (busy && wait_n > 0) begin
            wait_n <= wait_n - 1;
         end else if (busy) begin
            busy <= 1'b0;
            o_flash_valid <= 1'b1;
            last <= data;
         end
      end
   end
   // outside the answer cycle the data lines show a stale inverted byte
   assign o_flash_rdata = o_flash_valid ? last : ~last;
endmodule
`default_nettype wire

// file: verif/test_option_and_trim_loader.sv
/*
 * Self-checking bench for the option and trim loader, with a scoreboard
 * of trim and factory option working values.
 * Assumes the flash partner model in its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module test_option_and_trim_loader;
   import optld_pkg::*;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reset_req = 1'b0, i_stop_recover = 1'b0;
   logic [11:0] i_reg_addr = 12'h000;
   logic [7:0] i_reg_wdata = 8'h00, i_dbg_opt_wdata = 8'h00;
   logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_dbg_opt_wr = 1'b0, i_dbg_opt_rd = 1'b0;
   logic [15:0] i_prog_addr = 16'h0000;
   logic [4:0] i_dbg_opt_idx = 5'h00;
   logic i_info_locked = 1'b0, slow = 1'b0;
   logic [7:0] opt0 = 8'h5C, opt1 = 8'hA3;
   logic [7:0] o_reg_rdata, i_flash_rdata, o_dbg_opt_rdata, o_user_opt0, o_user_opt1, o_trim_val;
   logic [15:0] o_flash_addr;
   logic [5:0] o_info_addr;
   logic [4:0] o_trim_sel;
   logic o_flash_rd, o_info_rd, i_flash_valid, o_info_mapped, o_sys_hold;
   int bad_count = 0, checks_done = 0, cycles = 0;
   int trim_m[32];
   int fopt_m[32];

   option_and_trim_loader i_option_and_trim_loader (.i_ref_clk, .i_rst, .i_reset_req,
      .i_stop_recover, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .o_flash_rd, .o_flash_addr, .o_info_rd, .o_info_addr, .i_flash_rdata, .i_flash_valid,
      .i_prog_addr, .o_info_mapped, .i_dbg_opt_wr, .i_dbg_opt_rd, .i_dbg_opt_idx,
      .i_dbg_opt_wdata, .i_info_locked, .o_dbg_opt_rdata, .o_user_opt0, .o_user_opt1,
      .o_sys_hold, .o_trim_sel, .o_trim_val);
   flash_partner_model i_flash_partner_model (.i_ref_clk, .i_rst, .i_flash_rd(o_flash_rd),
      .i_flash_addr(o_flash_addr), .i_info_rd(o_info_rd), .i_info_addr(o_info_addr),
      .i_slow(slow), .i_opt0(opt0), .i_opt1(opt1), .o_flash_rdata(i_flash_rdata),
      .o_flash_valid(i_flash_valid));

   // ----------------------------------------
   // clock, watchdog and shared tasks
   // ----------------------------------------
   initial forever #5 i_ref_clk = ~i_ref_clk;
   // the whole run needs well under a thousand cycles, so this only trips on a hang
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   function automatic logic [7:0] info_byte(input int a);
      return 8'(a * 29) ^ 8'hA5;
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe, so sample just then
   task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask
   task automatic wait_hold;
      int n;
      n = 0;
      while (o_sys_hold !== 1'b0 && n < 1000) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
      check("hold_done", 8'(n < 1000), 8'h01);
   endtask
   task automatic restart(input logic stop);
      @(posedge i_ref_clk);
      if (stop) i_stop_recover <= 1'b1;
      else i_reset_req <= 1'b1;
      @(posedge i_ref_clk);
      i_stop_recover <= 1'b0;
      i_reset_req <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      wait_hold();
   endtask
   task automatic map_chk(input logic [15:0] a, input logic exp);
      @(posedge i_ref_clk);
      i_prog_addr <= a;
      @(posedge i_ref_clk);
      #1 check("mapped", 8'(o_info_mapped), 8'(exp));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      int k;
      void'($urandom(89));
      for (int i = 0; i < TRIM_COUNT; i++) begin
         trim_m[i] = info_byte(i + 32);
         fopt_m[i] = info_byte(i);
      end
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      wait_hold();
      check("opt0", o_user_opt0, 8'h5C);
      check("opt1", o_user_opt1, 8'hA3);
      reg_rd(TRIM_INDEX_OFF, d);
      check("index_rst", d, TRIM_INDEX_RST);
      // every entry, with junk in the reserved index bits
      for (int i = 0; i < TRIM_COUNT; i++) begin
         reg_wr(TRIM_INDEX_OFF, 8'(i) | 8'($urandom_range(7) << 5));
         reg_rd(TRIM_INDEX_OFF, d);
         check("index", d, 8'(i));
         reg_rd(TRIM_DATA_OFF, d);
         check("trim_rd", d, 8'(trim_m[i]));
         check("trim_sel", {3'b000, o_trim_sel}, 8'(i));
      end
      // writes at both ends of the index range, read twice to catch stepping
      for (int r = 0; r < 8; r++) begin
         k = (r == 0) ? 0 : (r == 1) ? 31 : $urandom_range(31);
         d = (r == 0) ? 8'hFF : 8'($urandom);
         trim_m[k] = d;
         reg_wr(TRIM_INDEX_OFF, 8'(k));
         reg_wr(TRIM_DATA_OFF, d);
         reg_rd(TRIM_DATA_OFF, d);
         check("trim_wr", d, 8'(trim_m[k]));
         reg_rd(TRIM_DATA_OFF, d);
         check("trim_again", d, 8'(trim_m[k]));
         check("trim_val", o_trim_val, 8'(trim_m[k]));
      end
      // new flash option bytes wait for a restart
      opt0 <= 8'h3E;
      opt1 <= 8'h71;
      repeat (4) @(posedge i_ref_clk);
      #1 check("opt_early", o_user_opt0, 8'h5C);
      slow <= 1'b1;
      restart(1'b1);
      check("opt0_stop", o_user_opt0, 8'h3E);
      check("opt1_stop", o_user_opt1, 8'h71);
      opt0 <= 8'hFF;
      opt1 <= 8'hFF;
      restart(1'b0);
      check("opt_erased", o_user_opt0 & o_user_opt1, 8'hFF);
      reg_rd(TRIM_DATA_OFF, d);
      check("trim_kept", d, 8'(trim_m[k]));
      // unmapped places read zero and leave the hidden options alone
      for (int i = 0; i < 3; i++) begin
         reg_wr(12'h0F0 + 12'(i * 12'h705), 8'($urandom));
         reg_rd(12'h0F0 + 12'(i * 12'h705), d);
         check("unmapped", d, 8'h00);
      end
      check("opt_hidden", o_user_opt1, 8'hFF);
      // debugger option writes, locked on even passes
      for (int i = 0; i < 4; i++) begin
         k = $urandom_range(31);
         d = 8'($urandom);
         if (i % 2 == 1) fopt_m[k] = d;
         @(posedge i_ref_clk);
         i_info_locked <= (i % 2 == 0);
         i_dbg_opt_idx <= 5'(k);
         i_dbg_opt_wdata <= d;
         i_dbg_opt_wr <= 1'b1;
         @(posedge i_ref_clk);
         i_dbg_opt_wr <= 1'b0;
         i_dbg_opt_rd <= 1'b1;
         @(posedge i_ref_clk);
         i_dbg_opt_rd <= 1'b0;
         #1 check("dbg_opt", o_dbg_opt_rdata, 8'(fopt_m[k]));
      end
      // information area window follows the select bit
      map_chk(16'hFC10, 1'b0);
      reg_wr(PAGE_PICK_OFF, 8'h80);
      map_chk(16'hFC10, 1'b1);
      map_chk(16'hFC57, 1'b1);
      map_chk(16'hFFFF, 1'b1);
      map_chk(16'hFBFF, 1'b0);
      reg_wr(PAGE_PICK_OFF, 8'h00);
      map_chk(16'hFC00, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
